// *** hw/sai_core.sv ***
// Servo alarm timing, over-speed check and pulse output shaping.
// Assumes APB master on pclk; encoder and scale pins are asynchronous.
//
// Local design decisions: the APB interface to the registers and the address map.
`timescale 1ns/1ps
`default_nettype none
module sai_core import sai_pkg::*; #(
  parameter int MS_CYCLES = CYC_PER_MS,
  parameter int SAVE_PERIOD_MS = SAVE_MS,
  parameter int EST_MINUTE_MS = EST_SLOW_MS,
  parameter int INIT_MS = INIT_BASE_MS
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Drive status inputs (same clock)
  input wire logic [15:0] motor_speed,
  input wire logic panel_edit,
  input wire logic est_active,
  input wire logic abs_zero,
  input wire logic scale_a_step,
  // Pins
  input wire logic alarm_pin,
  input wire logic stop_done_pin,
  input wire logic enc_a_pin,
  input wire logic enc_b_pin,
  input wire logic enc_z_pin,
  input wire logic scale_a_pin,
  input wire logic scale_b_pin,
  input wire logic scale_z_pin,
  // Drive status outputs
  output logic alarm_state,
  output logic estop_active,
  output logic alarm_latched,
  output logic second_overspeed_fault,
  output logic init_done,
  output logic nv_edit_write,
  output logic est_update,
  output logic est_save,
  output logic signed [7:0] disturbance_comp_gain,
  output logic [11:0] disturbance_filter_constant,
  // Pulse outputs to host
  output logic out_a,
  output logic out_b,
  output logic out_z
);
  ////////////////////////////////////////////////////////////////////
  logic [7:0] s1_reg, s2_reg, s3_reg;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1_reg <= 8'h00;
      s2_reg <= 8'h00;
      s3_reg <= 8'h00;
    end else begin
      s1_reg <= {alarm_pin, stop_done_pin, enc_a_pin, enc_b_pin,
                 enc_z_pin, scale_a_pin, scale_b_pin, scale_z_pin};
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
    end
  end
  wire alm = s2_reg[7];
  wire done = s2_reg[6];
  wire ea_rise = s2_reg[5] & ~s3_reg[5];
  wire ez = s2_reg[3];
  wire ez_rise = s2_reg[3] & ~s3_reg[3];
  wire [1:0] sab = s2_reg[2:1];
  wire sz = s2_reg[0];
  wire sz_rise = s2_reg[0] & ~s3_reg[0];
  wire alm_rise = s2_reg[7] & ~s3_reg[7];

  ////////////////////////////////////////////////////////////////////
  // Registers; power-cycle fields carry a staged and an effective copy
  logic full_closed_reg, serial_reg, panel_reg, panel_eff_reg, regen_reg, regen_eff_reg;
  logic [9:0] estop_reg;
  logic [3:0] latch_reg, latch_eff_reg;
  logic [14:0] ovs_reg, maxspd_reg, encw_reg, encw_eff_reg;
  logic [6:0] puw_reg;
  logic [8:0] szw_reg, szw_eff_reg;
  logic [28:0] absz_reg, absz_eff_reg;
  logic [1:0] est_reg;
  logic signed [7:0] gain_reg;
  logic [11:0] filt_reg;
  wire wr = psel & penable & pready & pwrite;
  wire w_ctrl = wr & (paddr == OFS_CTRL);
  wire w_estop = wr & (paddr == OFS_ESTOP);
  wire w_ovs = wr & (paddr == OFS_OVSPD);
  wire w_panel = wr & (paddr == OFS_PANEL);
  wire w_index = wr & (paddr == OFS_INDEX);
  wire w_absz = wr & (paddr == OFS_ABSZ);
  wire w_regen = wr & (paddr == OFS_REGEN);
  wire w_dist = wr & (paddr == OFS_DIST);
  // Out-of-range writes saturate so the logic never sees an illegal setting
  wire [9:0] wd_estop = (pwdata[9:0] > ESTOP_MAX) ? ESTOP_MAX : pwdata[9:0];
  wire [3:0] wd_latch = (pwdata[LATCH_LSB+:4] > LATCH_MAX) ? LATCH_MAX : pwdata[LATCH_LSB+:4];
  wire [14:0] wd_ovs = (pwdata[14:0] > OVSPD_MAX) ? OVSPD_MAX : pwdata[14:0];
  wire [6:0] wd_puw = (pwdata[PUW_LSB+:7] > PUW_MAX) ? PUW_MAX : pwdata[PUW_LSB+:7];
  wire [8:0] wd_szw = (pwdata[SZW_LSB+:9] > SZW_MAX) ? SZW_MAX : pwdata[SZW_LSB+:9];
  wire [28:0] wd_absz = (pwdata[28:0] > ABSZ_MAX) ? ABSZ_MAX : pwdata[28:0];
  wire [11:0] wd_filt = (pwdata[FILT_LSB+:12] > FILT_MAX) ? FILT_MAX : pwdata[FILT_LSB+:12];
  wire signed [31:0] wd_g32 = {{24{pwdata[7]}}, pwdata[7:0]};
  wire signed [7:0] wd_gain = (wd_g32 > 32'sd100) ? GAIN_MAX :
                              (wd_g32 < -32'sd100) ? GAIN_MIN : wd_g32[7:0];
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      full_closed_reg <= 1'b0; serial_reg <= 1'b0;
      estop_reg <= ESTOP_RST; latch_reg <= LATCH_RST;
      ovs_reg <= 15'h0000; maxspd_reg <= 15'h0000;
      panel_reg <= 1'b0; puw_reg <= 7'h00;
      encw_reg <= 15'h0000; szw_reg <= 9'h000; absz_reg <= 29'h00000000;
      regen_reg <= 1'b0; est_reg <= EST_RST;
      gain_reg <= 8'sh00; filt_reg <= FILT_RST;
    end else begin
      if (w_ctrl) {serial_reg, full_closed_reg} <= pwdata[1:0];
      if (w_estop) estop_reg <= wd_estop; // R01
      if (w_estop) latch_reg <= wd_latch; // R13
      if (w_ovs) ovs_reg <= wd_ovs; // R04
      if (w_ovs) maxspd_reg <= pwdata[MAXSPD_LSB+:15];
      if (w_panel) panel_reg <= pwdata[0];
      if (w_panel) puw_reg <= wd_puw; // R07
      if (w_index) encw_reg <= pwdata[14:0]; // R08
      if (w_index) szw_reg <= wd_szw; // R09
      if (w_absz) absz_reg <= wd_absz;
      if (w_regen) regen_reg <= pwdata[0];
      if (w_regen) est_reg <= pwdata[EST_LSB+:2]; // R15
      if (w_dist) gain_reg <= wd_gain; // R18
      if (w_dist) filt_reg <= wd_filt; // R19
    end
  end
  // Effective copies follow only until initialization ends
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      panel_eff_reg <= 1'b0; latch_eff_reg <= LATCH_RST; encw_eff_reg <= 15'h0000;
      szw_eff_reg <= 9'h000; absz_eff_reg <= 29'h00000000; regen_eff_reg <= 1'b0;
    end else if (!init_done) begin // R17
      panel_eff_reg <= panel_reg; latch_eff_reg <= latch_reg; encw_eff_reg <= encw_reg;
      szw_eff_reg <= szw_reg; absz_eff_reg <= absz_reg; regen_eff_reg <= regen_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // APB answer: pready rises in the access phase, zero extra waits
  wire mapped = (paddr[1:0] == 2'b00) && (paddr <= OFS_STAT);
  logic [31:0] rd;
  always_comb begin
    unique case (paddr)
      OFS_CTRL: rd = {30'h00000000, serial_reg, full_closed_reg};
      OFS_ESTOP: rd = {12'h000, latch_reg, 6'h00, estop_reg};
      OFS_OVSPD: rd = {1'b0, maxspd_reg, 1'b0, ovs_reg};
      OFS_PANEL: rd = {9'h000, puw_reg, 15'h0000, panel_reg};
      OFS_INDEX: rd = {7'h00, szw_reg, 1'b0, encw_reg};
      OFS_ABSZ: rd = {3'h0, absz_reg};
      OFS_REGEN: rd = {26'h0000000, est_reg, 3'h0, regen_reg};
      OFS_DIST: rd = {4'h0, filt_reg, 8'h00, gain_reg};
      OFS_STAT: rd = {26'h0000000, init_done, second_overspeed_fault,
                      alarm_latched, estop_active, alarm_state, alm};
      default: rd = 32'h00000000;
    endcase
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0; pslverr <= 1'b0; prdata <= 32'h00000000;
    end else begin
      pready <= psel & ~penable;
      pslverr <= psel & ~penable & ~mapped;
      prdata <= (psel & ~penable & ~pwrite) ? rd : 32'h00000000;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Common millisecond and microsecond ticks
  logic [$clog2(MS_CYCLES+1)-1:0] msc_reg;
  logic [3:0] usc_reg;
  logic ms_tick, us_tick;
  // Wrap on the last count so each tick period is exactly one unit
  wire ms_wrap = (msc_reg == ($bits(msc_reg))'(MS_CYCLES - 1));
  wire us_wrap = (usc_reg == 4'(CYC_PER_US - 1));
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      msc_reg <= '0; ms_tick <= 1'b0; usc_reg <= 4'h0; us_tick <= 1'b0;
    end else begin
      ms_tick <= ms_wrap; // R20
      msc_reg <= ms_wrap ? '0 : msc_reg + 1'b1;
      us_tick <= us_wrap;
      usc_reg <= us_wrap ? 4'h0 : usc_reg + 4'h1;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Alarm: timed emergency stop, then alarm state
  sai_state_e st_reg, st_next;
  logic [9:0] stop_ms_reg;
  logic [13:0] latch_ms_reg;
  wire clr_latch = w_ctrl & pwdata[CLR_LATCH_BIT];
  wire stop_expired = (stop_ms_reg >= estop_reg);
  wire [13:0] latch_lim = 14'(latch_eff_reg * SEC_MS);
  wire latch_expire = alarm_latched && (latch_eff_reg != 4'h0) && ms_tick
                      && (latch_ms_reg + 14'h1 >= latch_lim);
  always_comb begin
    st_next = st_reg;
    unique case (st_reg)
      ST_IDLE: if (alm_rise) st_next = (estop_reg == 10'h000) ? ST_ALARM : ST_ESTOP; // R03
      ST_ESTOP: if (done) st_next = ST_IDLE;
        else if (stop_expired) st_next = ST_ALARM; // R02
      ST_ALARM: if (!alm && !alarm_latched) st_next = ST_IDLE;
      default: st_next = ST_IDLE;
    endcase
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_reg <= ST_IDLE; stop_ms_reg <= 10'h000;
      alarm_state <= 1'b0; estop_active <= 1'b0;
    end else begin
      st_reg <= st_next;
      alarm_state <= (st_next == ST_ALARM);
      estop_active <= (st_next == ST_ESTOP);
      if (st_reg != ST_ESTOP) stop_ms_reg <= 10'h000; // R20
      else if (ms_tick) stop_ms_reg <= stop_ms_reg + 10'h001;
    end
  end
  // Latch: onset wins over a software clear in the same cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      alarm_latched <= 1'b0; latch_ms_reg <= 14'h0000;
    end else if (alm_rise) begin
      alarm_latched <= 1'b1; latch_ms_reg <= 14'h0000; // R20
    end else if (clr_latch || latch_expire) begin // R13
      alarm_latched <= 1'b0;
    end else if (alarm_latched && ms_tick && latch_ms_reg != 14'h3FFF) begin
      latch_ms_reg <= latch_ms_reg + 14'h0001;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Second over-speed, sticky until cleared
  wire [16:0] max12 = 17'((32'(maxspd_reg) * OVS_MUL) / OVS_DIV);
  wire [16:0] ovs_thr = (ovs_reg == 15'h0000) ? max12 : {2'b00, ovs_reg}; // R05
  wire ovs_hit = ({1'b0, motor_speed} > ovs_thr);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) second_overspeed_fault <= 1'b0;
    else if (ovs_hit) second_overspeed_fault <= 1'b1; // R04
    else if (w_ctrl & pwdata[CLR_OVS_BIT]) second_overspeed_fault <= 1'b0;
  end

  ////////////////////////////////////////////////////////////////////
  // Power-up wait and panel edit store
  logic [13:0] pu_ms_reg;
  wire [13:0] pu_lim = 14'(INIT_MS) + 14'(puw_reg * INIT_STEP_MS);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pu_ms_reg <= 14'h0000; init_done <= 1'b0; nv_edit_write <= 1'b0;
    end else begin
      if (!init_done && ms_tick) pu_ms_reg <= pu_ms_reg + 14'h0001;
      if (pu_ms_reg >= pu_lim) init_done <= 1'b1; // R07
      nv_edit_write <= panel_edit & panel_eff_reg; // R06
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Load estimation update and periodic save
  logic [16:0] upd_ms_reg;
  logic [21:0] save_ms_reg;
  wire [16:0] upd_lim = (est_reg == 2'h1) ? 17'(EST_MINUTE_MS) :
                        (est_reg == 2'h2) ? 17'(EST_MID_MS) : 17'h00001;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      upd_ms_reg <= 17'h00000; save_ms_reg <= 22'h000000;
      est_update <= 1'b0; est_save <= 1'b0;
    end else begin
      est_update <= 1'b0;
      est_save <= 1'b0;
      if (!est_active || est_reg == 2'h0) begin // R16
        upd_ms_reg <= 17'h00000;
      end else if (ms_tick) begin
        if (upd_ms_reg + 17'h1 >= upd_lim) begin
          upd_ms_reg <= 17'h00000; est_update <= 1'b1; // R15
        end else upd_ms_reg <= upd_ms_reg + 17'h00001;
      end
      if (!est_active) save_ms_reg <= 22'h000000;
      else if (ms_tick) begin
        if (save_ms_reg + 22'h1 >= 22'(SAVE_PERIOD_MS)) begin
          save_ms_reg <= 22'h000000; est_save <= 1'b1; // R14
        end else save_ms_reg <= save_ms_reg + 22'h000001;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Index shaping
  logic [14:0] ez_left_reg;
  logic [8:0] sz_left_reg;
  logic [28:0] az_cnt_reg;
  logic az_armed_reg, az_reg;
  logic [1:0] qd_reg;
  wire az_int = (absz_eff_reg != 29'h0);
  wire az_hit = az_armed_reg && scale_a_step && (az_cnt_reg + 29'h1 >= absz_eff_reg);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ez_left_reg <= 15'h0000; sz_left_reg <= 9'h000;
      az_cnt_reg <= 29'h0; az_armed_reg <= 1'b0; az_reg <= 1'b0; qd_reg <= 2'b00;
    end else begin
      if (ez_rise) ez_left_reg <= encw_eff_reg; // R08
      else if (ea_rise && ez_left_reg != 15'h0000) ez_left_reg <= ez_left_reg - 15'h0001;
      if (sz_rise) sz_left_reg <= szw_eff_reg; // R09
      else if (us_tick && sz_left_reg != 9'h000) sz_left_reg <= sz_left_reg - 9'h001;
      if (abs_zero && (!az_int || !az_armed_reg)) begin // R10
        az_reg <= 1'b1; az_armed_reg <= az_int; az_cnt_reg <= 29'h0; // R21
      end else if (az_int && az_hit) begin
        az_reg <= 1'b1; az_cnt_reg <= 29'h0; // R11
      end else if (scale_a_step) begin
        az_reg <= 1'b0;
        if (az_armed_reg) az_cnt_reg <= az_cnt_reg + 29'h1;
      end
      if (^(sab ^ qd_reg)) qd_reg <= sab; // Illegal double steps are dropped
    end
  end

  ////////////////////////////////////////////////////////////////////
  wire z_enc = ez | (ez_left_reg != 15'h0000);
  wire z_scale = sz | (sz_left_reg != 9'h000);
  wire [1:0] ab_scale = regen_eff_reg ? qd_reg : sab; // R12
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      out_a <= 1'b0; out_b <= 1'b0; out_z <= 1'b0;
      disturbance_comp_gain <= 8'sh00; disturbance_filter_constant <= FILT_RST;
    end else begin
      {out_a, out_b} <= full_closed_reg ? ab_scale : s2_reg[5:4];
      out_z <= !full_closed_reg ? z_enc : serial_reg ? az_reg : z_scale;
      disturbance_comp_gain <= gain_reg;
      disturbance_filter_constant <= filt_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////
  sequence s_onset_zero;
    alm_rise && st_reg == ST_IDLE && estop_reg == 10'h000;
  endsequence
  property p_immediate_stop;
    @(posedge pclk) disable iff (!presetn) s_onset_zero |=> alarm_state && !estop_active;
  endproperty
  a_immediate_stop: assert property (p_immediate_stop) else $error("no immediate stop"); // R03
  property p_stop_timeout;
    @(posedge pclk) disable iff (!presetn)
      st_reg == ST_ESTOP && !done && stop_expired |=> alarm_state;
  endproperty
  a_stop_timeout: assert property (p_stop_timeout) else $error("stop timeout missed"); // R02
  property p_no_early_alarm;
    @(posedge pclk) disable iff (!presetn)
      st_reg == ST_ESTOP && !stop_expired |=> !alarm_state;
  endproperty
  a_no_early_alarm: assert property (p_no_early_alarm) else $error("alarm too early"); // R01
  property p_ovs;
    @(posedge pclk) disable iff (!presetn)
      {1'b0, motor_speed} > ovs_thr |=> second_overspeed_fault [*2];
  endproperty
  a_ovs: assert property (p_ovs) else $error("over-speed fault not held"); // R04
  property p_ovs_default;
    @(posedge pclk) disable iff (!presetn)
      ovs_reg == 15'h0000 && !second_overspeed_fault
      && 32'(motor_speed) * OVS_DIV <= 32'(maxspd_reg) * OVS_MUL |=> !second_overspeed_fault;
  endproperty
  a_ovs_default: assert property (p_ovs_default) else $error("wrong default level"); // R05
  property p_panel;
    @(posedge pclk) disable iff (!presetn) panel_edit |=> nv_edit_write == panel_eff_reg;
  endproperty
  a_panel: assert property (p_panel) else $error("panel store mismatch"); // R06
  property p_init;
    @(posedge pclk) disable iff (!presetn) init_done && !$past(init_done) |->
      $past(pu_ms_reg) >= $past(pu_lim);
  endproperty
  a_init: assert property (p_init) else $error("init ended early"); // R07
  sequence s_enc_idx;
    !full_closed_reg && ez_rise && encw_eff_reg != 15'h0000;
  endsequence
  property p_enc_stretch;
    @(posedge pclk) disable iff (!presetn) s_enc_idx ##1 !full_closed_reg |=> out_z;
  endproperty
  a_enc_stretch: assert property (p_enc_stretch) else $error("index not stretched"); // R08
  property p_abs_zero;
    @(posedge pclk) disable iff (!presetn)
      abs_zero && !az_armed_reg |=> az_reg ##0 (az_armed_reg == az_int);
  endproperty
  a_abs_zero: assert property (p_abs_zero) else $error("zero index missing"); // R11
  property p_hold;
    @(posedge pclk) disable iff (!presetn) init_done && !w_estop |=> $stable(latch_eff_reg);
  endproperty
  a_hold: assert property (p_hold) else $error("power-cycle field moved"); // R17
endmodule
`default_nettype wire

// *** hw/sai_pkg.sv ***
// Constants for the servo alarm and index output block.
// Assumes a 10 MHz APB clock and a control-power reset on presetn.
//
// Overview of operation
// (R01) Emergency-stop limit in 1 ms units, 0..1000, default 200.
// (R02) Stop not done when the limit runs out puts the drive into alarm state.
// (R03) Limit of zero skips the timed stop and stops on alarm at once.
// (R04) Speed above the second over-speed level raises the over-speed fault; level up to 20000.
// (R05) Level of zero uses 1.2 times the motor maximum speed.
// (R06) Panel write select 1 stores each panel edit at once; 0 does not.
// (R07) Initialization waits 1.5 s plus setting times 0.1 s; setting 0..100.
// (R08) Encoder index output stretched by a width in pulses, 0..32767.
// (R09) Full-closed scale index held for a least time, 0..400 us.
// (R10) Interval zero: scale index only at absolute zero position.
// (R11) Nonzero interval: index at first zero, then every set count of A pulses.
// (R12) Regeneration 0 passes A, B, Z; 1 regenerates A, B and passes Z.
// (R13) Alarm latch time: 0 latches forever, 1..10 seconds, default 5.
// (R14) Active load estimation saves its result every 30 minutes.
// (R15) Estimation speed setting 0..3; higher follows load changes faster.
// (R16) Speed 0 stops, 1 each minute, 2 each second, 3 fastest.
// (R17) Power-cycle settings take effect only at the next power-up.
// (R18) Disturbance compensating gain is signed, -100..100, default 0.
// (R19) Disturbance filter constant in 0.01 ms units, up to 2500, default 53.
// (R20) Stop and latch timers share one millisecond tick, started at alarm onset.
// (R21) Index interval counter clears at power-up, restarts at first absolute zero.

package sai_pkg;
  localparam int CLK_HZ = 10_000_000;
  localparam int TICK_MS = 1;
  localparam int CYC_PER_MS = CLK_HZ / 1000 * TICK_MS;
  localparam int TICK_US = 1;
  localparam int CYC_PER_US = CLK_HZ / 1_000_000 * TICK_US;
  localparam int INIT_BASE_S_X10 = 15;
  localparam int INIT_BASE_MS = INIT_BASE_S_X10 * 100;
  localparam int INIT_STEP_MS = 100;
  localparam int SAVE_MIN = 30;
  localparam int SAVE_MS = SAVE_MIN * 60 * 1000;
  localparam int EST_SLOW_MS = 60_000;
  localparam int EST_MID_MS = 1000;
  localparam int SEC_MS = 1000;
  // Default second over-speed level is max speed times MUL over DIV
  localparam int OVS_MUL = 6;
  localparam int OVS_DIV = 5;
  // Register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_ESTOP = 8'h04;
  localparam logic [7:0] OFS_OVSPD = 8'h08;
  localparam logic [7:0] OFS_PANEL = 8'h0C;
  localparam logic [7:0] OFS_INDEX = 8'h10;
  localparam logic [7:0] OFS_ABSZ = 8'h14;
  localparam logic [7:0] OFS_REGEN = 8'h18;
  localparam logic [7:0] OFS_DIST = 8'h1C;
  localparam logic [7:0] OFS_STAT = 8'h20;
  // Field limits and reset values
  localparam logic [9:0] ESTOP_MAX = 10'h3E8;
  localparam logic [9:0] ESTOP_RST = 10'h0C8;
  localparam logic [3:0] LATCH_MAX = 4'hA;
  localparam logic [3:0] LATCH_RST = 4'h5;
  localparam logic [14:0] OVSPD_MAX = 15'h4E20;
  localparam logic [6:0] PUW_MAX = 7'h64;
  localparam logic [8:0] SZW_MAX = 9'h190;
  localparam logic [28:0] ABSZ_MAX = 29'h10000000;
  localparam logic [1:0] EST_RST = 2'h1;
  localparam logic [11:0] FILT_MAX = 12'h9C4;
  localparam logic [11:0] FILT_RST = 12'h035;
  localparam logic signed [7:0] GAIN_MAX = 8'sh64;
  localparam logic signed [7:0] GAIN_MIN = -8'sh64;
  // Field positions
  localparam int LATCH_LSB = 16;
  localparam int MAXSPD_LSB = 16;
  localparam int PUW_LSB = 16;
  localparam int SZW_LSB = 16;
  localparam int EST_LSB = 4;
  localparam int FILT_LSB = 16;
  localparam int CLR_LATCH_BIT = 8;
  localparam int CLR_OVS_BIT = 9;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_ESTOP = 2'b01,
    ST_ALARM = 2'b10
  } sai_state_e;
endpackage

// *** sim/sai_host_model.sv ***
// Host controller model that counts the drive's A and Z pulse outputs.
// Assumes the outputs are clean levels in the pclk domain.
`timescale 1ns/1ps
`default_nettype none
module sai_host_model (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Pulses from the drive
  input wire logic out_a,
  input wire logic out_b,
  input wire logic out_z,
  // Observed counts
  output var int a_rises,
  output var int z_rises
);
  logic a_q;
  logic z_q;
  ////////////////////////////////////////////////////////////////////////////
  // Edge counting, as a host counter input would see it
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      a_rises <= 0;
      z_rises <= 0;
      a_q <= 1'b0;
      z_q <= 1'b0;
    end else begin
      a_q <= out_a;
      z_q <= out_z;
      if (out_a === 1'b1 && a_q === 1'b0) a_rises <= a_rises + 1;
      if (out_z === 1'b1 && z_q === 1'b0) z_rises <= z_rises + 1;
    end
  end
endmodule
`default_nettype wire

// *** sim/tb.sv ***
// Self-checking bench for the servo alarm and pulse output block.
// Assumes sai_core with shortened timer parameters and the host model.
`timescale 1ns/1ps
`default_nettype none
module tb;
  import sai_pkg::*;
  localparam int MS = 4;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, err, alarm_state, estop_active, alarm_latched, ovs, init_done;
  logic nv_edit_write, est_update, est_save, out_a, out_b, out_z;
  logic [15:0] motor_speed = 16'h0;
  logic panel_edit = 0, est_active = 0, alarm_pin = 0, stop_done_pin = 0;
  logic abs_zero = 0, scale_a_step = 0;
  logic [2:0] enc = 3'h0, scl = 3'h0;
  logic signed [7:0] gain;
  logic [11:0] filt;
  int error_cnt = 0, check_count = 0, n, c_upd, c_sav, a_rises, z_rises;
  integer seed = 32'h2a38;
  always #50 pclk = ~pclk;
  sai_core #(.MS_CYCLES(MS), .SAVE_PERIOD_MS(20), .EST_MINUTE_MS(10), .INIT_MS(5)) dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .motor_speed(motor_speed), .panel_edit(panel_edit), .est_active(est_active),
    .abs_zero(abs_zero), .scale_a_step(scale_a_step), .alarm_pin(alarm_pin),
    .stop_done_pin(stop_done_pin), .enc_a_pin(enc[0]), .enc_b_pin(enc[1]), .enc_z_pin(enc[2]),
    .scale_a_pin(scl[0]), .scale_b_pin(scl[1]), .scale_z_pin(scl[2]),
    .alarm_state(alarm_state), .estop_active(estop_active), .alarm_latched(alarm_latched),
    .second_overspeed_fault(ovs), .init_done(init_done), .nv_edit_write(nv_edit_write),
    .est_update(est_update), .est_save(est_save), .disturbance_comp_gain(gain),
    .disturbance_filter_constant(filt), .out_a(out_a), .out_b(out_b), .out_z(out_z));
  sai_host_model host (.pclk(pclk), .presetn(presetn), .out_a(out_a), .out_b(out_b),
    .out_z(out_z), .a_rises(a_rises), .z_rises(z_rises));
  //////////////////////////////////////////////////////////////////////////////
  task automatic end_sim();
    if (error_cnt == 0 && check_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  // One APB transfer; the request holds until pready is seen high
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 16);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    chk(k < 16, 1);
    if (k >= 16) end_sim();
  endtask
  // Fault cleared at zero speed, then a new level and speed applied
  task automatic ovs_try(input logic [31:0] w, input logic [15:0] spd, input logic exp);
    motor_speed <= 16'h0;
    apb(1, OFS_CTRL, 32'h0000_0200);
    apb(1, OFS_OVSPD, w);
    motor_speed <= spd;
    repeat (3) @(posedge pclk);
    chk(ovs, exp);
  endtask
  //////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    apb(1, OFS_PANEL, 32'h0000_0001);
    apb(1, OFS_ABSZ, 32'h0000_0002);
    apb(1, OFS_INDEX, 32'h0005_0003);
    for (n = 9; n < 100 && init_done !== 1'b1; n++) @(posedge pclk);
    chk(n >= 4 * MS && n <= 7 * MS, 1);
    apb(0, OFS_ESTOP, 0);
    chk(rd, {12'h0, LATCH_RST, 6'h0, ESTOP_RST});
    apb(0, OFS_REGEN, 0);
    chk(rd, {26'h0, EST_RST, 4'h0});
    apb(0, 8'h24, 0);
    chk({31'h0, err}, 32'h1);
    chk(rd, 32'h0);
    apb(1, OFS_DIST, 32'h0035_007F);
    apb(0, OFS_DIST, 0);
    chk(rd, 32'h0035_0064);
    chk({gain, filt}, {GAIN_MAX, FILT_RST});
    apb(1, OFS_DIST, 32'h0FFF_0080);
    repeat (2) @(posedge pclk);
    chk({gain, filt}, {GAIN_MIN, FILT_MAX});
    // Select written to 0 after init must not take effect yet
    apb(1, OFS_PANEL, 32'h0);
    panel_edit <= 1'b1;
    @(posedge pclk);
    panel_edit <= 1'b0;
    @(posedge pclk);
    chk(nv_edit_write, 1);
    ovs_try(32'h0000_03E8, 16'($unsigned($random(seed)) % 1001), 0);
    ovs_try(32'h0000_03E8, 16'h03E9, 1);
    ovs_try(32'h03E8_0000, 16'h04B0, 0);
    ovs_try(32'h03E8_0000, 16'h04B1, 1);
    apb(1, OFS_ESTOP, 32'h0005_0003);
    alarm_pin <= 1'b1;
    repeat (6) @(posedge pclk);
    chk({estop_active, alarm_state}, 2'b10);
    for (n = 6; n < 100 && alarm_state !== 1'b1; n++) @(posedge pclk);
    chk({n >= 3 * MS && n <= 3 * MS + 8, alarm_latched}, 2'b11);
    alarm_pin <= 1'b0;
    apb(1, OFS_CTRL, 32'h0000_0100);
    repeat (4) @(posedge pclk);
    chk(alarm_state, 0);
    apb(1, OFS_ESTOP, 32'h0005_0000);
    alarm_pin <= 1'b1;
    for (n = 0; n < 100 && alarm_state !== 1'b1; n++) @(posedge pclk);
    chk({estop_active, n <= 6}, 2'b01);
    alarm_pin <= 1'b0;
    // Full-closed, direct regeneration: scale pins reach the host
    apb(1, OFS_CTRL, 32'h0000_0101);
    for (n = 0; n < 10; n++) begin
      scl <= {n == 4, 1'($random(seed)), ~scl[0]};
      enc <= 3'($random(seed));
      repeat (2) @(posedge pclk);
    end
    repeat (6) @(posedge pclk);
    chk(a_rises, 5);
    chk(z_rises, 1);
    chk(out_z, 1);
    chk(out_b, scl[1]);
    // Serial scale, interval 2: zero index, then every second A step
    apb(1, OFS_CTRL, 32'h0000_0003);
    for (n = 0; n < 5; n++) begin
      abs_zero <= (n == 0);
      scale_a_step <= (n != 0);
      @(posedge pclk);
    end
    scale_a_step <= 1'b0;
    repeat (4) @(posedge pclk);
    chk(z_rises, 4);
    est_active <= 1'b1;
    c_upd = 0;
    c_sav = 0;
    for (n = 0; n < 200; n++) begin
      @(posedge pclk);
      c_upd += (est_update === 1'b1);
      c_sav += (est_save === 1'b1);
    end
    chk({c_upd >= 4 && c_upd <= 6, c_sav >= 1 && c_sav <= 3}, 2'b11);
    // Fastest speed updates on every millisecond tick
    apb(1, OFS_REGEN, 32'h0000_0030);
    c_upd = 0;
    repeat (40) begin
      @(posedge pclk);
      c_upd += (est_update === 1'b1);
    end
    chk(c_upd >= 9 && c_upd <= 11, 1);
    end_sim();
  end
endmodule
`default_nettype wire
